// ---- hw/epiu_pkg.sv ----
// Constants, field layouts and helpers of the external pin interrupt unit
`default_nettype none
package epiu_pkg;
	localparam int unsigned ADDR_W = 18;
	localparam int unsigned DATA_W = 32;

	// Register indices; the byte address is four times the index
	localparam logic [15:0] IDX_EDGE   = 16'hFFF2;
	localparam logic [15:0] IDX_ENA    = 16'hFFF3;
	localparam logic [15:0] IDX_FLAG   = 16'hFFF6;
	localparam logic [15:0] IDX_ROUTE  = 16'hF085;
	localparam logic [15:0] IDX_PBMODE = 16'hF086;
	localparam logic [15:0] IDX_AEDGE  = 16'hF087;
	localparam logic [15:0] IDX_CCODE  = 16'hF088;
	localparam logic [15:0] IDX_ISTAT  = 16'hF089;
	localparam logic [15:0] IDX_IMASK  = 16'hF08A;

	// Register widths
	localparam int unsigned EDGE_W  = 4;
	localparam int unsigned ENA_W   = 4;
	localparam int unsigned FLAG_W  = 3;
	localparam int unsigned ROUTE_W = 4;
	localparam int unsigned PBM_W   = 2;
	localparam int unsigned IS_W    = 5;

	// Field positions
	localparam int unsigned EDGE_ZERO  = 0;
	localparam int unsigned EDGE_ONE   = 1;
	localparam int unsigned EDGE_CONVERSION_TRIGGER_INPUT = 2;
	localparam int unsigned EDGE_NMI   = 3;
	localparam int unsigned ENA_ZERO   = 0;
	localparam int unsigned ENA_ONE    = 1;
	localparam int unsigned ENA_AEC    = 2;
	localparam int unsigned ENA_RTC    = 3;
	localparam int unsigned FLAG_ZERO  = 0;
	localparam int unsigned FLAG_ONE   = 1;
	localparam int unsigned FLAG_AEC   = 2;
	localparam int unsigned ROUTE_ZERO = 0;
	localparam int unsigned ROUTE_ONE  = 2;
	localparam int unsigned PBM_ZERO   = 0;
	localparam int unsigned PBM_ONE    = 1;
	localparam int unsigned IS_CONVERSION_TRIGGER_INPUT   = 3;
	localparam int unsigned IS_NMI     = 4;

	// Reset values
	localparam logic [EDGE_W-1:0]  EDGE_RST  = 4'h0;
	localparam logic [ENA_W-1:0]   ENA_RST   = 4'h0;
	localparam logic [FLAG_W-1:0]  FLAG_RST  = 3'h0;
	localparam logic [ROUTE_W-1:0] ROUTE_RST = 4'h0;
	localparam logic [PBM_W-1:0]   PBM_RST   = 2'h0;
	localparam logic               AEDGE_RST = 1'h0;
	localparam logic               IMASK_RST = 1'h1;
	localparam logic [IS_W-1:0]    IS_RST    = 5'h00;

	// Synchroniser lanes: alternates of request zero, of request one, then single pins
	localparam int unsigned N_IN     = 9;
	localparam int unsigned LN_ZERO  = 0;
	localparam int unsigned LN_ONE   = 3;
	localparam int unsigned LN_NMI   = 6;
	localparam int unsigned LN_CONVERSION_TRIGGER_INPUT = 7;
	localparam int unsigned LN_AEC   = 8;

	typedef logic [1:0] epiu_route_t;
	localparam epiu_route_t ROUTE_PB   = 2'h0;
	localparam epiu_route_t ROUTE_NONE = 2'h3;

	// Effective source of a request input; port B source needs its mode bit
	function automatic epiu_route_t epiu_route_sel(input epiu_route_t code,
		input logic pb_on);
		if (code == ROUTE_NONE)
			return ROUTE_NONE;
		if (code == ROUTE_PB && !pb_on)
			return ROUTE_NONE;
		return code;
	endfunction

	// Pick one of three alternates; a detached input reads dflt
	function automatic logic epiu_pick(input logic [2:0] v, input epiu_route_t s,
		input logic dflt);
		return (s == ROUTE_NONE) ? dflt : v[s];
	endfunction

	// Selected edge: one means rising, zero means falling
	function automatic logic epiu_edge_hit(input logic rise, input logic fall,
		input logic sel);
		return sel ? rise : fall;
	endfunction

	function automatic logic epiu_mapped(input logic [15:0] idx);
		case (idx)
			IDX_EDGE, IDX_ENA, IDX_FLAG, IDX_ROUTE, IDX_PBMODE,
			IDX_AEDGE, IDX_CCODE, IDX_ISTAT, IDX_IMASK: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
endpackage
`default_nettype wire

// ---- hw/epiu_edge_if.sv ----
// Carrier between the pin synchroniser and the interrupt logic
`default_nettype none
interface epiu_edge_if #(parameter int unsigned N = 9);
	logic [N-1:0] raw;
	logic [N-1:0] level;
	logic [N-1:0] rise;
	logic [N-1:0] fall;
	modport det (input raw, output level, output rise, output fall);
	modport user (output raw, input level, input rise, input fall);
endinterface
`default_nettype wire

// ---- hw/epiu_edge_det.sv ----
// Three-stage pin synchroniser with filtered level and edge pulses
`default_nettype none
module epiu_edge_det #(
	parameter int unsigned N = 9
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins in, level and edges out
	epiu_edge_if.det e
);
	logic [N-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, rise_ff, fall_ff;
	logic [N-1:0] nxt_s1, nxt_s2, nxt_s3, nxt_lvl, nxt_rise, nxt_fall;

	always_comb begin
		nxt_s1 = e.raw;
		nxt_s2 = s1_ff;
		nxt_s3 = s2_ff;
		nxt_lvl = lvl_ff;
		// Level moves only when stages two and three agree
		for (int i = 0; i < N; i++) begin
			if (s2_ff[i] == s3_ff[i])
				nxt_lvl[i] = s3_ff[i];
		end
		nxt_rise = nxt_lvl & ~lvl_ff;
		nxt_fall = ~nxt_lvl & lvl_ff;
	end

	// Idle level of the request pins is high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_ff <= '1;
			s2_ff <= '1;
			s3_ff <= '1;
			lvl_ff <= '1;
			rise_ff <= '0;
			fall_ff <= '0;
		end else begin
			s1_ff <= nxt_s1;
			s2_ff <= nxt_s2;
			s3_ff <= nxt_s3;
			lvl_ff <= nxt_lvl;
			rise_ff <= nxt_rise;
			fall_ff <= nxt_fall;
		end
	end

	assign e.level = lvl_ff;
	assign e.rise = rise_ff;
	assign e.fall = fall_ff;
endmodule
`default_nettype wire

// ---- hw/epiu_apb_slave.sv ----
// APB decode: zero-wait answer, strobes and error on unmapped words
`default_nettype none
module epiu_apb_slave
	import epiu_pkg::*;
#(
	parameter int unsigned AW = ADDR_W
) (
	// APB request
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [AW-1:0] paddr,
	// APB answer
	output logic              pready,
	output logic              pslverr,
	// Decoded strobes
	output logic              wr_stb,
	output logic              rd_setup,
	output logic              done,
	output logic [15:0]       idx
);
	logic ok;

	assign idx = paddr[17:2];
	assign ok = (paddr[1:0] == 2'h0) && epiu_mapped(idx);
	assign pready = 1'b1;
	assign done = psel & penable;
	assign pslverr = done & ~ok;
	assign wr_stb = done & pwrite & ok;
	// Read data is captured in the setup cycle so it stands through the access
	assign rd_setup = psel & ~penable & ~pwrite;
endmodule
`default_nettype wire

// ---- hw/epiu_top.sv ----
// External pin interrupt unit: edge select, flags, enables, masking, routing
//
// Added by the designer: the address map and register access over APB.
`default_nettype none
module epiu_top
	import epiu_pkg::*;
#(
	parameter int unsigned AW = ADDR_W
) (
	// Clock and reset
	input wire logic              pclk,
	input wire logic              presetn,
	// APB slave
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [AW-1:0]     paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic     [DATA_W-1:0] prdata,
	output logic                  pready,
	output logic                  pslverr,
	// Request pins: three alternates each for requests zero and one, then single pins
	input wire logic [2:0]        pin_request_zero,
	input wire logic [2:0]        pin_request_one,
	input wire logic              nmi_pin,
	input wire logic              conversion_trigger_input,
	input wire logic              event_counter_request,
	// Real-time clock request from on-chip logic
	input wire logic              rtc_event,
	// Requests to the core
	output logic                  cpu_req_zero,
	output logic                  cpu_req_one,
	output logic                  cpu_req_aec,
	output logic                  cpu_req_rtc,
	output logic                  nmi_req,
	output logic                  adc_trigger,
	output logic                  irq
);
	logic              wr_stb, rd_setup, done;
	logic [15:0]       idx;
	logic [3:0]        wb;

	logic [EDGE_W-1:0]  edge_select_reg_ff, nxt_edge_select_reg;
	logic [ENA_W-1:0]   request_enable_reg_ff, nxt_request_enable_reg;
	logic [FLAG_W-1:0]  request_flag_reg_ff, nxt_request_flag_reg;
	logic [ROUTE_W-1:0] pin_routing_reg_ff, nxt_pin_routing_reg;
	logic [PBM_W-1:0]   port_b_mode_reg_ff, nxt_port_b_mode_reg;
	logic               event_edge_select_reg_ff, nxt_event_edge_select_reg;
	logic               condition_code_ff, nxt_condition_code;
	logic [IS_W-1:0]    istat_ff, nxt_istat;
	logic [IS_W-1:0]    imask_ff, nxt_imask;
	logic [FLAG_W-1:0]  hold_ff, nxt_hold;
	logic [DATA_W-1:0]  prdata_ff, nxt_prdata;
	logic [3:0]         req_ff, nxt_req;
	logic               nmi_ff, nxt_nmi;
	logic               conversion_trigger_input_ff, nxt_conversion_trigger_input;
	logic               irq_ff, nxt_irq;

	epiu_route_t       sel0, sel1, nsel0, nsel1;
	logic [FLAG_W-1:0] hit, sw, fset;
	logic              nmi_hit, conversion_trigger_input_hit;
	logic              old0, new0, old1, new1;

	epiu_edge_if #(.N(N_IN)) sif ();

	// Every lane, including unrouted alternates, is synchronised so that
	// a routing change sees a settled level on the new pin at once
	assign sif.raw = {event_counter_request, conversion_trigger_input, nmi_pin,
		pin_request_one, pin_request_zero};

	epiu_edge_det #(.N(N_IN)) u_edge (
		.pclk    (pclk),
		.presetn (presetn),
		.e       (sif)
	);

	epiu_apb_slave #(.AW(AW)) u_apb (
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.pready   (pready),
		.pslverr  (pslverr),
		.wr_stb   (wr_stb),
		.rd_setup (rd_setup),
		.done     (done),
		.idx      (idx)
	);

	assign wb = pwdata[3:0];

	// Control registers written by software
	always_comb begin
		nxt_edge_select_reg = edge_select_reg_ff;
		nxt_request_enable_reg = request_enable_reg_ff;
		nxt_pin_routing_reg = pin_routing_reg_ff;
		nxt_port_b_mode_reg = port_b_mode_reg_ff;
		nxt_event_edge_select_reg = event_edge_select_reg_ff;
		nxt_condition_code = condition_code_ff;
		nxt_imask = imask_ff;
		if (wr_stb) begin
			case (idx)
				IDX_EDGE: nxt_edge_select_reg = wb;
				IDX_ENA: nxt_request_enable_reg = wb;
				IDX_ROUTE: nxt_pin_routing_reg = wb;
				IDX_PBMODE: nxt_port_b_mode_reg = wb[PBM_W-1:0];
				IDX_AEDGE: nxt_event_edge_select_reg = wb[0];
				IDX_CCODE: nxt_condition_code = wb[0];
				IDX_IMASK: nxt_imask = pwdata[IS_W-1:0];
				default: ;
			endcase
		end
	end

	// Effective sources before and after this cycle's write
	assign sel0 = epiu_route_sel(pin_routing_reg_ff[ROUTE_ZERO +: 2],
		port_b_mode_reg_ff[PBM_ZERO]);
	assign sel1 = epiu_route_sel(pin_routing_reg_ff[ROUTE_ONE +: 2],
		port_b_mode_reg_ff[PBM_ONE]);
	assign nsel0 = epiu_route_sel(nxt_pin_routing_reg[ROUTE_ZERO +: 2],
		nxt_port_b_mode_reg[PBM_ZERO]);
	assign nsel1 = epiu_route_sel(nxt_pin_routing_reg[ROUTE_ONE +: 2],
		nxt_port_b_mode_reg[PBM_ONE]);

	// A detached input reads high, so it never makes an edge
	assign old0 = epiu_pick(sif.level[LN_ZERO +: 3], sel0, 1'b1);
	assign new0 = epiu_pick(sif.level[LN_ZERO +: 3], nsel0, 1'b1);
	assign old1 = epiu_pick(sif.level[LN_ONE +: 3], sel1, 1'b1);
	assign new1 = epiu_pick(sif.level[LN_ONE +: 3], nsel1, 1'b1);

	// Edge detection on the routed pin of each request
	always_comb begin
		hit[FLAG_ZERO] = epiu_edge_hit(
			epiu_pick(sif.rise[LN_ZERO +: 3], sel0, 1'b0),
			epiu_pick(sif.fall[LN_ZERO +: 3], sel0, 1'b0),
			edge_select_reg_ff[EDGE_ZERO]);
		hit[FLAG_ONE] = epiu_edge_hit(
			epiu_pick(sif.rise[LN_ONE +: 3], sel1, 1'b0),
			epiu_pick(sif.fall[LN_ONE +: 3], sel1, 1'b0),
			edge_select_reg_ff[EDGE_ONE]);
		hit[FLAG_AEC] = epiu_edge_hit(sif.rise[LN_AEC], sif.fall[LN_AEC],
			event_edge_select_reg_ff);
		nmi_hit = epiu_edge_hit(sif.rise[LN_NMI], sif.fall[LN_NMI],
			edge_select_reg_ff[EDGE_NMI]);
		conversion_trigger_input_hit = epiu_edge_hit(sif.rise[LN_CONVERSION_TRIGGER_INPUT], sif.fall[LN_CONVERSION_TRIGGER_INPUT],
			edge_select_reg_ff[EDGE_CONVERSION_TRIGGER_INPUT]);
	end

	// Switching a pin function sets the flag unless both the old and the new
	// source sit high through the switch
	always_comb begin
		sw[FLAG_ZERO] = wr_stb && (nsel0 != sel0) && !(old0 && new0);
		sw[FLAG_ONE] = wr_stb && (nsel1 != sel1) && !(old1 && new1);
		sw[FLAG_AEC] = wr_stb && (nxt_event_edge_select_reg != event_edge_select_reg_ff)
			&& !sif.level[LN_AEC];
	end

	// The spurious set is held until the next bus transfer has completed, so
	// a clear issued as the very next access loses against it
	always_comb begin
		nxt_hold = (hold_ff & ~{FLAG_W{done}}) | sw;
		fset = hit | sw | hold_ff;
	end

	// Request flags: writing zero clears, writing one keeps, a set wins
	always_comb begin
		nxt_request_flag_reg = request_flag_reg_ff;
		if (wr_stb && idx == IDX_FLAG)
			nxt_request_flag_reg = request_flag_reg_ff & pwdata[FLAG_W-1:0];
		nxt_request_flag_reg = nxt_request_flag_reg | fset;
	end

	// Event status for the level interrupt: write one clears, a set wins
	always_comb begin
		nxt_istat = istat_ff;
		if (wr_stb && idx == IDX_ISTAT)
			nxt_istat = istat_ff & ~pwdata[IS_W-1:0];
		nxt_istat = nxt_istat | {nmi_hit, conversion_trigger_input_hit, hit | sw};
		nxt_irq = |(istat_ff & imask_ff);
	end

	// Requests to the core; the non-maskable one bypasses both gates
	always_comb begin
		nxt_req[0] = request_flag_reg_ff[FLAG_ZERO]
			& request_enable_reg_ff[ENA_ZERO] & ~condition_code_ff;
		nxt_req[1] = request_flag_reg_ff[FLAG_ONE]
			& request_enable_reg_ff[ENA_ONE] & ~condition_code_ff;
		nxt_req[2] = request_flag_reg_ff[FLAG_AEC]
			& request_enable_reg_ff[ENA_AEC] & ~condition_code_ff;
		nxt_req[3] = rtc_event & request_enable_reg_ff[ENA_RTC]
			& ~condition_code_ff;
		nxt_nmi = nmi_hit;
		nxt_conversion_trigger_input = conversion_trigger_input_hit;
	end

	// Read data captured in the setup cycle
	always_comb begin
		nxt_prdata = prdata_ff;
		if (rd_setup) begin
			nxt_prdata = '0;
			case (idx)
				IDX_EDGE: nxt_prdata[EDGE_W-1:0] = edge_select_reg_ff;
				IDX_ENA: nxt_prdata[ENA_W-1:0] = request_enable_reg_ff;
				IDX_FLAG: nxt_prdata[FLAG_W-1:0] = request_flag_reg_ff;
				IDX_ROUTE: nxt_prdata[ROUTE_W-1:0] = pin_routing_reg_ff;
				IDX_PBMODE: nxt_prdata[PBM_W-1:0] = port_b_mode_reg_ff;
				IDX_AEDGE: nxt_prdata[0] = event_edge_select_reg_ff;
				IDX_CCODE: nxt_prdata[0] = condition_code_ff;
				IDX_ISTAT: nxt_prdata[IS_W-1:0] = istat_ff;
				IDX_IMASK: nxt_prdata[IS_W-1:0] = imask_ff;
				default: nxt_prdata = '0;
			endcase
		end
	end

	// Software-written control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_select_reg_ff <= EDGE_RST;
			request_enable_reg_ff <= ENA_RST;
			pin_routing_reg_ff <= ROUTE_RST;
			port_b_mode_reg_ff <= PBM_RST;
			event_edge_select_reg_ff <= AEDGE_RST;
			condition_code_ff <= IMASK_RST;
			imask_ff <= IS_RST;
		end else begin
			edge_select_reg_ff <= nxt_edge_select_reg;
			request_enable_reg_ff <= nxt_request_enable_reg;
			pin_routing_reg_ff <= nxt_pin_routing_reg;
			port_b_mode_reg_ff <= nxt_port_b_mode_reg;
			event_edge_select_reg_ff <= nxt_event_edge_select_reg;
			condition_code_ff <= nxt_condition_code;
			imask_ff <= nxt_imask;
		end
	end

	// Request flags and the pending spurious set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			request_flag_reg_ff <= FLAG_RST;
			hold_ff <= FLAG_RST;
		end else begin
			request_flag_reg_ff <= nxt_request_flag_reg;
			hold_ff <= nxt_hold;
		end
	end

	// Event status and the level interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_ff <= IS_RST;
			irq_ff <= 1'b0;
		end else begin
			istat_ff <= nxt_istat;
			irq_ff <= nxt_irq;
		end
	end

	// Registered requests to the core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_ff <= 4'h0;
			nmi_ff <= 1'b0;
			conversion_trigger_input_ff <= 1'b0;
		end else begin
			req_ff <= nxt_req;
			nmi_ff <= nxt_nmi;
			conversion_trigger_input_ff <= nxt_conversion_trigger_input;
		end
	end

	// Read data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= '0;
		end else begin
			prdata_ff <= nxt_prdata;
		end
	end

	assign prdata = prdata_ff;
	assign cpu_req_zero = req_ff[0];
	assign cpu_req_one = req_ff[1];
	assign cpu_req_aec = req_ff[2];
	assign cpu_req_rtc = req_ff[3];
	assign nmi_req = nmi_ff;
	assign adc_trigger = conversion_trigger_input_ff;
	assign irq = irq_ff;
endmodule
`default_nettype wire

// ---- verif/epiu_monitor.sv ----
// Port checker of the external pin interrupt unit
`default_nettype none
module epiu_monitor
	import epiu_pkg::*;
#(
	parameter int unsigned AW = ADDR_W
) (
	// Clock and reset
	input wire logic              pclk,
	input wire logic              presetn,
	// Register bus
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [AW-1:0]     paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// Requests
	input wire logic              rtc_event,
	input wire logic              cpu_req_zero,
	input wire logic              cpu_req_one,
	input wire logic              cpu_req_aec,
	input wire logic              cpu_req_rtc,
	input wire logic              nmi_req,
	input wire logic              adc_trigger,
	input wire logic              irq
);
	logic [ENA_W-1:0] ena_ff;
	logic [ENA_W-1:0] nxt_ena;
	logic             gmask_ff;
	logic             nxt_gmask;
	logic [IS_W-1:0]  imask_ff;
	logic [IS_W-1:0]  nxt_imask;
	logic             wr_hit;
	// Shadows of the gating registers, with the design's reset values
	always_comb begin
		wr_hit = psel && penable && pwrite && paddr[1:0] == 2'h0;
		nxt_ena = ena_ff;
		nxt_gmask = gmask_ff;
		nxt_imask = imask_ff;
		if (wr_hit && paddr[AW-1:2] == IDX_ENA)
			nxt_ena = pwdata[ENA_W-1:0];
		if (wr_hit && paddr[AW-1:2] == IDX_CCODE)
			nxt_gmask = pwdata[0];
		if (wr_hit && paddr[AW-1:2] == IDX_IMASK)
			nxt_imask = pwdata[IS_W-1:0];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ena_ff <= ENA_RST;
			gmask_ff <= IMASK_RST;
			imask_ff <= IS_RST;
		end else begin
			ena_ff <= nxt_ena;
			gmask_ff <= nxt_gmask;
			imask_ff <= nxt_imask;
		end
	end
	a_rtc_gated: assert property (@(posedge pclk) disable iff (!presetn)
		cpu_req_rtc == $past(rtc_event && ena_ff[ENA_RTC] && !gmask_ff))
		else $error("rtc request not gated by enable and mask");
	a_mask_blocks_all: assert property (@(posedge pclk) disable iff (!presetn)
		gmask_ff |=> !(cpu_req_zero || cpu_req_one || cpu_req_aec || cpu_req_rtc))
		else $error("request passed the global mask");
	a_enable_zero: assert property (@(posedge pclk) disable iff (!presetn)
		!ena_ff[ENA_ZERO] |=> !cpu_req_zero)
		else $error("request zero passed a cleared enable");
	a_enable_one: assert property (@(posedge pclk) disable iff (!presetn)
		!ena_ff[ENA_ONE] |=> !cpu_req_one)
		else $error("request one passed a cleared enable");
	a_enable_aec: assert property (@(posedge pclk) disable iff (!presetn)
		!ena_ff[ENA_AEC] |=> !cpu_req_aec)
		else $error("event request passed a cleared enable");
	a_nmi_single: assert property (@(posedge pclk) disable iff (!presetn)
		nmi_req |=> !nmi_req)
		else $error("nmi pulse longer than one cycle");
	a_trig_single: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(adc_trigger) |=> $fell(adc_trigger))
		else $error("trigger pulse longer than one cycle");
	a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
		imask_ff == '0 |=> !irq)
		else $error("irq raised with every source masked");
endmodule
bind epiu_top epiu_monitor #(.AW(AW)) u_mon (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.rtc_event(rtc_event), .cpu_req_zero(cpu_req_zero), .cpu_req_one(cpu_req_one),
	.cpu_req_aec(cpu_req_aec), .cpu_req_rtc(cpu_req_rtc), .nmi_req(nmi_req),
	.adc_trigger(adc_trigger), .irq(irq));
`default_nettype wire

// ---- verif/epiu_pin_src.sv ----
// Model of the external sources driving the request pins
`default_nettype none
module epiu_pin_src (
	// Clock
	input wire logic       pclk,
	// Pins: three alternates per request, then nmi, trigger, event counter
	output var logic [8:0] pins
);
	timeunit 1ns;
	timeprecision 1ps;
	// Sources idle high, so a routing switch sets no flag
	initial pins = '1;
	task automatic set(input int ln, input logic v);
		@(posedge pclk);
		pins[ln] <= v;
	endtask
endmodule
`default_nettype wire

// ---- verif/epiu_top_tb.sv ----
// Self-checking bench of the external pin interrupt unit
`default_nettype none
module epiu_top_tb import epiu_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] RIX [8] = '{IDX_EDGE, IDX_ENA, IDX_FLAG, IDX_ROUTE, IDX_PBMODE,
		IDX_AEDGE, IDX_CCODE, IDX_ISTAT};
	localparam logic [31:0] RRV [8] = '{6: 32'h1, default: 32'h0};
	logic              pclk, presetn, psel, penable, pwrite, rtc_event;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata;
	logic              pready, pslverr, rz, ro, ra, rr, nmi, adc, irq;
	logic [8:0]        pins;
	logic [33:0]       expq[$];
	int                err_total, check_count, nmi_cnt, adc_cnt;
	int                seed = 97282;
	epiu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_request_zero(pins[2:0]), .pin_request_one(pins[5:3]),
		.nmi_pin(pins[6]), .conversion_trigger_input(pins[7]),
		.event_counter_request(pins[8]), .rtc_event(rtc_event), .cpu_req_zero(rz),
		.cpu_req_one(ro), .cpu_req_aec(ra), .cpu_req_rtc(rr), .nmi_req(nmi),
		.adc_trigger(adc), .irq(irq));
	epiu_pin_src src (.pclk(pclk), .pins(pins));
	initial begin
		pclk = 1'h0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic lvl(input string nm, input logic e, input logic g);
		cmp(nm, {31'h0, e}, {31'h0, g});
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Read entries carry the expected data, write entries the data sent
	task automatic apb(input logic w, input logic [15:0] ix, input logic [31:0] d,
		input logic er);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {ix, 2'h0};
		pwdata <= w ? d : 32'h0;
		expq.push_back({w, er, d});
		@(posedge pclk);
		penable <= 1'h1;
		// Only the watchdog ends a wait whose answer never comes
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [15:0] ix, input logic [31:0] d);
		apb(1'h1, ix, d, 1'h0);
	endtask
	task automatic rd(input logic [15:0] ix, input logic [31:0] e);
		apb(1'h0, ix, e, 1'h0);
	endtask
	// Ends off the edge so that registered outputs have settled
	task automatic gap(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask
	task automatic pulse(input int ln);
		src.set(ln, 1'h0);
		gap(8);
		src.set(ln, 1'h1);
		gap(8);
	endtask
	always @(posedge pclk) begin
		logic [33:0] x;
		rtc_event <= 1'($random(seed));
		nmi_cnt += int'(nmi);
		adc_cnt += int'(adc);
		if (psel && penable && pready && expq.size() > 0) begin
			x = expq.pop_front();
			cmp("pslverr", {31'h0, x[32]}, {31'h0, pslverr});
			if (!x[33])
				cmp("prdata", x[31:0], prdata);
		end
	end
	// Whole sequence needs under 500 cycles; this is far beyond it
	initial begin
		#100us;
		err_total++;
		stop_test();
	end
	initial begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = '0;
		pwdata = 32'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		for (int i = 0; i < 8; i++) rd(RIX[i], RRV[i]);
		apb(1'h0, 16'h0001, 32'h0, 1'h1);
		apb(1'h1, 16'h0001, 32'hFFFFFFFF, 1'h1);
		wr(IDX_IMASK, 32'h0);
		$display("reset test done");
		wr(IDX_PBMODE, 32'h3);
		for (int c = 0; c < 3; c++) begin
			wr(IDX_ROUTE, 32'(c));
			pulse((c + 1) % 3);
			rd(IDX_FLAG, 32'h0);
			pulse(c);
			rd(IDX_FLAG, 32'h1);
			wr(IDX_FLAG, 32'h7);
			rd(IDX_FLAG, 32'h1);
			wr(IDX_FLAG, 32'h0);
			rd(IDX_FLAG, 32'h0);
		end
		wr(IDX_ROUTE, 32'h3);
		pulse(0);
		rd(IDX_FLAG, 32'h0);
		wr(IDX_ROUTE, 32'h7);
		wr(IDX_EDGE, 32'h2);
		src.set(4, 1'h0);
		gap(8);
		rd(IDX_FLAG, 32'h0);
		src.set(4, 1'h1);
		gap(8);
		rd(IDX_FLAG, 32'h2);
		$display("routing and edge test done");
		wr(IDX_FLAG, 32'h0);
		wr(IDX_ROUTE, 32'h5);
		src.set(1, 1'h0);
		gap(8);
		wr(IDX_FLAG, 32'h0);
		wr(IDX_ROUTE, 32'h6);
		wr(IDX_FLAG, 32'h0);
		rd(IDX_FLAG, 32'h1);
		wr(IDX_FLAG, 32'h0);
		rd(IDX_FLAG, 32'h0);
		src.set(1, 1'h1);
		$display("switch test done");
		wr(IDX_ISTAT, 32'h1F);
		pulse(2);
		wr(IDX_CCODE, 32'h0);
		gap(2);
		lvl("cpu_req_zero", 1'h0, rz);
		wr(IDX_ENA, 32'hF);
		gap(2);
		lvl("cpu_req_zero", 1'h1, rz);
		wr(IDX_CCODE, 32'h1);
		gap(2);
		lvl("cpu_req_zero", 1'h0, rz);
		wr(IDX_CCODE, 32'h0);
		gap(2);
		lvl("irq", 1'h0, irq);
		wr(IDX_IMASK, 32'h1);
		gap(2);
		lvl("irq", 1'h1, irq);
		wr(IDX_ISTAT, 32'h1);
		gap(2);
		lvl("irq", 1'h0, irq);
		rd(IDX_ISTAT, 32'h0);
		$display("enable and mask test done");
		wr(IDX_FLAG, 32'h0);
		for (int ln = 6; ln < 9; ln++) pulse(ln);
		cmp("nmi pulses", 32'h1, 32'(nmi_cnt));
		cmp("trigger pulses", 32'h1, 32'(adc_cnt));
		lvl("cpu_req_aec", 1'h1, ra);
		pulse(4);
		lvl("cpu_req_one", 1'h1, ro);
		rd(IDX_FLAG, 32'h6);
		rd(IDX_ISTAT, 32'h1E);
		gap(4);
		$display("source test done");
		stop_test();
	end
endmodule
`default_nettype wire
